// ### verilog/dmt_seq_regs.svh
// Register map, field positions, reset values and fixed counts for the training symbol sequencer.
// Assumes a 32-bit AHB-Lite register bus with byte addresses decoded on the low eight bits.
`ifndef DMT_SEQ_REGS_SVH
`define DMT_SEQ_REGS_SVH

// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_NTONES 8'h04
`define REG_CE_LEN 8'h08
`define REG_TONE_LO 8'h0c
`define REG_TONE_HI 8'h10
`define REG_MSG_CODE 8'h14
`define REG_IDLE_BYTE 8'h18
`define REG_MSG_LEN 8'h1c
`define REG_MSG_DATA 8'h20
`define REG_TA 8'h24
`define REG_STATUS 8'h28

// Control register bit positions.
`define CTRL_TRAIN_BIT 0
`define CTRL_CENTRAL_BIT 1
`define CTRL_PSD_SEL_BIT 2
`define CTRL_EC_REQ_BIT 3
`define CTRL_SYNC_GO_BIT 4

// Message data register fields.
`define MSG_DATA_BYTE_MSB 7
`define MSG_DATA_IDX_LSB 8
`define MSG_DATA_IDX_MSB 12

// Status register fields.
`define STAT_ITER_MSB 7
`define STAT_MSG_LSB 8
`define STAT_MSG_MSB 9
`define STAT_SYNC_ACT_BIT 10
`define STAT_SYNC_DONE_BIT 11

// Reset values.
`define NTONES_RST 13'h0100
`define CE_LEN_RST 12'h040
`define TONE_LO_RST 13'h0001
`define TONE_HI_RST 13'h00ff
`define MSG_CODE_RST 8'h00
`define IDLE_BYTE_RST 8'h00
`define ITER_FIRST 8'h01

// Default timing advance: a 7.5 us loop delay expressed in transmit samples.
`define TA_DEFAULT_NS 7500
`define TX_SAMPLE_MHZ 35
`define TA_DEFAULT_SMP (16'((`TA_DEFAULT_NS * `TX_SAMPLE_MHZ) / 1000))

// Fixed message bytes.
`define ACK_BYTE 8'h00
`define NACK_BYTE 8'hff
`define EC_NONE_BYTE 8'h00
`define EC_REQ_BYTE 8'hff

// Synchronisation burst and acknowledge timing, in symbols.
`define SYNC_LAST 4'd14
`define SYNC_MID_FIRST 4'd5
`define SYNC_MID_LAST 4'd9
`define ACK_DELAY 3'd5
`define ACK_APPLY 3'd1

// Constellation values, scrambler seed and point levels.
`define VAL_ONES 2'b11
`define VAL_ZERO 2'b00
`define SCR_SEED 11'h7ff
`define PT_POS 2'sb01
`define PT_NIL 2'sb00
`define MOD10_LAST 4'd9
`define HTRANS_ACTIVE_BIT 1

`endif

// ### verilog/dmt_seq_pkg.sv
// Types shared by the training symbol sequencer: states, the tone carrier and the module state record.
// Assumes the constants of dmt_seq_regs.svh for register layout.
`default_nettype none

package dmt_seq_pkg;

  typedef enum logic [1:0] {SYM_IDLE, SYM_TONES, SYM_WAIT} sym_state_t;
  typedef enum logic [1:0] {MSG_IDLE, MSG_PSD, MSG_ACK, MSG_NACK} msg_state_t;

  // One mapped tone: index, enable and signed unit coordinates.
  typedef struct packed {
    logic [12:0] idx;
    logic en;
    logic signed [1:0] x;
    logic signed [1:0] y;
  } tone_pt_t;

  typedef struct packed {
    logic train_en;
    logic central;
    logic psd_sel;
    logic ec_req;
    logic [12:0] ntones;
    logic [11:0] ce_len;
    logic [12:0] tone_lo;
    logic [12:0] tone_hi;
    logic [7:0] msg_code;
    logic [7:0] idle_byte;
    logic [5:0] msg_len;
    logic [31:0][7:0] msg_buf;
    logic [15:0] ta;
    logic [15:0] ta_prev;
    logic [15:0] ta_corr;
    logic [7:0] iter;
    logic iter_adv;
    logic [31:0] rd_data;
    logic wr_pend;
    logic [7:0] wr_addr;
    sym_state_t sym_st;
    logic [12:0] tone;
    logic [3:0] mod10;
    logic [10:0] scr;
    logic [13:0] smp_cnt;
    logic sync_pend;
    logic sync_act;
    logic [3:0] sync_cnt;
    logic sync_done;
    msg_state_t msg_st;
    logic [5:0] ptr;
    logic [7:0] cur_byte;
    logic last_ack;
    logic ack_wait;
    logic [2:0] ack_cnt;
    logic upd_pend;
    logic upd_ok;
    logic rep_pend;
    logic tone_valid;
    tone_pt_t tone_pt;
    logic sym_start;
  } seq_state_t;

endpackage

`default_nettype wire

// ### verilog/dmt_training_symbol_sequencer.sv
// Transmit sequencer for the end of the DMT training state: overhead message bytes, training
// symbols and the 15-symbol synchronisation burst, mapped tone by tone with quadrant rotation.
// Assumes an AHB-Lite register bus, a sample strobe and tone consumer on the same 20 MHz clock,
// and a receiver that reports gain updates and repeat requests as one-cycle pulses.
//
// Summary of operation
// - Downstream sync burst: 15 symbols, 4QAM.
// - Sync: 11 first/last five, 00 middle.
// - Sync points rotated by scrambler pair.
// - Scrambler reset at every symbol start.
// - Symbol spans transform plus extension samples; here longer while the tone consumer stalls.
// - PSD message: code, descriptor, echo flag.
// - Initial PSD chosen by signature selector byte.
// - PSD message repeats until first update.
// - Acknowledge is byte 00, sent once.
// - Iteration advances five symbols after acknowledge.
// - Repeat request: back, resend, advance again.
// - Reject is byte FF, sent once.
// - Training symbols, then upstream sync burst.
// - Training uses all allowed tones, 4QAM.
// - First iteration uses default timing advance; here only reset loads it, a training start keeps the current TA.
// - Later iterations change only level, advance.
// - One message byte per training symbol.
// - Odd tones 1-7 of each ten carry byte pairs by index.
// - Value 00 maps to first quadrant.
// - DC tone is never rotated.
// - Scrambler taps nine and eleven, seed ones.
// - Two bits per tone, DC forced 00.
// - Rotation table per scrambler bit pair.
// - Upstream sync burst: 15 symbols, same pattern.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`default_nettype none
`include "dmt_seq_regs.svh"

module dmt_training_symbol_sequencer
  import dmt_seq_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic [31:0] O_HRDATA,
  output logic O_HRESP,
  input wire logic I_SAMPLE_STB,
  input wire logic I_TONE_READY,
  output logic O_TONE_VALID,
  output tone_pt_t O_TONE,
  output logic O_SYM_START,
  input wire logic I_UPDATE_RX,
  input wire logic I_UPDATE_OK,
  input wire logic [15:0] I_TA_CORR,
  input wire logic I_REPEAT_RX,
  output logic [15:0] O_TIMING_ADV,
  output logic [7:0] O_ITERATION,
  output logic O_PSD_SEL,
  output logic O_SYNC_DONE
);

  seq_state_t r;
  seq_state_t n;

  // Negates a unit coordinate.
  function automatic logic signed [1:0] neg(input logic signed [1:0] v);
    neg = 2'(~v + 2'sb01);
  endfunction

  // Combinational next state: bus writes first, then the symbol machine, then event capture.
  always_comb begin
    logic addr_ok;
    logic start_sym;
    logic go;
    logic emit;
    logic [13:0] total;
    logic b0;
    logic b1;
    logic [10:0] s1;
    logic [1:0] rot;
    logic [1:0] val;
    logic [2:0] pair;
    logic signed [1:0] px;
    logic signed [1:0] py;
    n = r;
    n.sym_start = 1'b0;
    start_sym = 1'b0;
    go = 1'b0;
    emit = 1'b0;
    b0 = 1'b0;
    b1 = 1'b0;
    s1 = '0;
    rot = '0;
    val = '0;
    pair = '0;
    px = '0;
    py = '0;
    total = {1'b0, r.ntones} + {2'b0, r.ce_len};
    addr_ok = I_HSEL && I_HTRANS[`HTRANS_ACTIVE_BIT] && I_HREADY;

    // Bus address phase: latch writes for the data phase, sample read data now.
    n.wr_pend = addr_ok && I_HWRITE;
    n.wr_addr = I_HADDR[7:0];
    if (addr_ok && !I_HWRITE) begin
      if (I_HADDR[7:0] == `REG_CTRL) begin
        n.rd_data = 32'({r.ec_req, r.psd_sel, r.central, r.train_en});
      end else if (I_HADDR[7:0] == `REG_NTONES) begin
        n.rd_data = 32'(r.ntones);
      end else if (I_HADDR[7:0] == `REG_CE_LEN) begin
        n.rd_data = 32'(r.ce_len);
      end else if (I_HADDR[7:0] == `REG_TONE_LO) begin
        n.rd_data = 32'(r.tone_lo);
      end else if (I_HADDR[7:0] == `REG_TONE_HI) begin
        n.rd_data = 32'(r.tone_hi);
      end else if (I_HADDR[7:0] == `REG_MSG_CODE) begin
        n.rd_data = 32'(r.msg_code);
      end else if (I_HADDR[7:0] == `REG_IDLE_BYTE) begin
        n.rd_data = 32'(r.idle_byte);
      end else if (I_HADDR[7:0] == `REG_MSG_LEN) begin
        n.rd_data = 32'(r.msg_len);
      end else if (I_HADDR[7:0] == `REG_TA) begin
        n.rd_data = 32'(r.ta);
      end else if (I_HADDR[7:0] == `REG_STATUS) begin
        n.rd_data = 32'({r.sync_done, r.sync_act, r.msg_st, r.iter});
      end else begin
        n.rd_data = '0;
      end
    end

    // Bus data phase: store write data; the sync request bit is a one-shot.
    if (r.wr_pend) begin
      if (r.wr_addr == `REG_CTRL) begin
        n.train_en = I_HWDATA[`CTRL_TRAIN_BIT];
        n.central = I_HWDATA[`CTRL_CENTRAL_BIT];
        n.psd_sel = I_HWDATA[`CTRL_PSD_SEL_BIT];
        n.ec_req = I_HWDATA[`CTRL_EC_REQ_BIT];
        if (I_HWDATA[`CTRL_SYNC_GO_BIT]) begin
          n.sync_pend = 1'b1;
          n.sync_done = 1'b0;
        end
        if (I_HWDATA[`CTRL_TRAIN_BIT] && !r.train_en) begin
          n.msg_st = n.central ? MSG_IDLE : MSG_PSD;
          n.ptr = '0;
          n.iter = `ITER_FIRST;
          n.iter_adv = 1'b0;
          n.ack_wait = 1'b0;
          n.ta_prev = r.ta;
        end
      end else if (r.wr_addr == `REG_NTONES) begin
        n.ntones = I_HWDATA[12:0];
      end else if (r.wr_addr == `REG_CE_LEN) begin
        n.ce_len = I_HWDATA[11:0];
      end else if (r.wr_addr == `REG_TONE_LO) begin
        n.tone_lo = I_HWDATA[12:0];
      end else if (r.wr_addr == `REG_TONE_HI) begin
        n.tone_hi = I_HWDATA[12:0];
      end else if (r.wr_addr == `REG_MSG_CODE) begin
        n.msg_code = I_HWDATA[7:0];
      end else if (r.wr_addr == `REG_IDLE_BYTE) begin
        n.idle_byte = I_HWDATA[7:0];
      end else if (r.wr_addr == `REG_MSG_LEN) begin
        n.msg_len = I_HWDATA[5:0];
      end else if (r.wr_addr == `REG_MSG_DATA) begin
        n.msg_buf[I_HWDATA[`MSG_DATA_IDX_MSB:`MSG_DATA_IDX_LSB]] = I_HWDATA[`MSG_DATA_BYTE_MSB:0];
      end else if (r.wr_addr == `REG_TA) begin
        n.ta = I_HWDATA[15:0];
      end
    end

    go = (n.train_en || n.sync_pend || r.sync_act) && (r.ntones != '0);

    // Sample counter: a symbol lasts at least transform length plus extension samples and ends once its last tone is taken.
    if (r.sym_st != SYM_IDLE && I_SAMPLE_STB && r.smp_cnt < total) begin
      n.smp_cnt = r.smp_cnt + 14'd1;
    end

    // Symbol machine.
    case (r.sym_st)
      SYM_IDLE: begin
        start_sym = go;
      end
      SYM_TONES: begin
        emit = !r.tone_valid || I_TONE_READY;
      end
      SYM_WAIT: begin
        if (r.tone_valid && I_TONE_READY) begin
          n.tone_valid = 1'b0;
        end
        if ((!r.tone_valid || I_TONE_READY) && r.smp_cnt == total) begin
          // Symbol end: burst counting and the delayed iteration step.
          if (r.sync_act) begin
            if (r.sync_cnt == `SYNC_LAST) begin
              n.sync_act = 1'b0;
              n.sync_done = 1'b1;
              n.train_en = 1'b0;
            end else begin
              n.sync_cnt = r.sync_cnt + 4'd1;
            end
          end
          if (r.ack_wait) begin
            n.ack_cnt = r.ack_cnt - 3'd1;
            if (r.ack_cnt == `ACK_APPLY) begin
              n.ack_wait = 1'b0;
              n.iter = r.iter + 8'd1;
              n.iter_adv = 1'b1;
              n.ta_prev = r.ta;
              n.ta = r.ta + r.ta_corr;
            end
          end
          start_sym = n.train_en || n.sync_pend || n.sync_act;
          if (!start_sym) begin
            n.sym_st = SYM_IDLE;
          end
        end
      end
      default: begin
        n.sym_st = SYM_IDLE;
      end
    endcase

    // Map one tone: two scrambler bits, value by symbol type, then rotation.
    if (emit) begin
      b0 = r.scr[8] ^ r.scr[10];
      s1 = {r.scr[9:0], b0};
      b1 = s1[8] ^ s1[10];
      n.scr = {s1[9:0], b1};
      rot = (r.tone == '0) ? `VAL_ZERO : {b0, b1};
      pair = 3'(r.mod10[3:1]);
      if (r.sync_act) begin
        val = (r.sync_cnt < `SYNC_MID_FIRST || r.sync_cnt > `SYNC_MID_LAST) ? `VAL_ONES : `VAL_ZERO;
      end else if (r.mod10[0] && r.mod10 != `MOD10_LAST) begin
        val = {r.cur_byte[{pair[1:0], 1'b1}], r.cur_byte[{pair[1:0], 1'b0}]};
      end else begin
        val = `VAL_ZERO;
      end
      px = val[1] ? neg(`PT_POS) : `PT_POS;
      py = val[0] ? neg(`PT_POS) : `PT_POS;
      n.tone_valid = 1'b1;
      n.tone_pt.idx = r.tone;
      n.tone_pt.en = (r.tone >= r.tone_lo) && (r.tone <= r.tone_hi);
      case (rot)
        2'b00: begin
          n.tone_pt.x = px;
          n.tone_pt.y = py;
        end
        2'b01: begin
          n.tone_pt.x = neg(py);
          n.tone_pt.y = px;
        end
        2'b11: begin
          n.tone_pt.x = neg(px);
          n.tone_pt.y = neg(py);
        end
        default: begin
          n.tone_pt.x = py;
          n.tone_pt.y = neg(px);
        end
      endcase
      if (!n.tone_pt.en) begin
        n.tone_pt.x = `PT_NIL;
        n.tone_pt.y = `PT_NIL;
      end
      n.tone = r.tone + 13'd1;
      n.mod10 = (r.mod10 == `MOD10_LAST) ? 4'd0 : r.mod10 + 4'd1;
      if (r.tone == r.ntones - 13'd1) begin
        n.sym_st = SYM_WAIT;
      end
    end

    // Symbol start: reseed the scrambler, pick the burst or the next message byte.
    if (start_sym) begin
      n.sym_st = SYM_TONES;
      n.sym_start = 1'b1;
      n.scr = `SCR_SEED;
      n.tone = '0;
      n.mod10 = '0;
      n.smp_cnt = '0;
      if (n.sync_pend && !n.sync_act) begin
        n.sync_pend = 1'b0;
        n.sync_act = 1'b1;
        n.sync_cnt = '0;
      end
      if (r.upd_pend) begin
        n.upd_pend = 1'b0;
        n.msg_st = r.upd_ok ? MSG_ACK : MSG_NACK;
        n.iter_adv = 1'b0;
      end else if (r.rep_pend) begin
        n.rep_pend = 1'b0;
        if (r.last_ack) begin
          n.msg_st = MSG_ACK;
          if (r.iter_adv) begin
            n.iter = r.iter - 8'd1;
            n.ta = r.ta_prev;
            n.iter_adv = 1'b0;
          end
        end else begin
          n.msg_st = MSG_NACK;
        end
      end
      case (n.msg_st)
        MSG_PSD: begin
          // The pointer is read from n so that a fresh training start restarts at the code byte.
          if (n.ptr == '0) begin
            n.cur_byte = r.msg_code;
          end else if (n.ptr <= r.msg_len) begin
            n.cur_byte = r.msg_buf[5'(n.ptr - 6'd1)];
          end else begin
            n.cur_byte = r.ec_req ? `EC_REQ_BYTE : `EC_NONE_BYTE;
          end
          n.ptr = (n.ptr > r.msg_len) ? 6'd0 : n.ptr + 6'd1;
        end
        MSG_ACK: begin
          n.cur_byte = `ACK_BYTE;
          n.last_ack = 1'b1;
          n.ack_wait = 1'b1;
          n.ack_cnt = `ACK_DELAY;
          n.msg_st = MSG_IDLE;
        end
        MSG_NACK: begin
          n.cur_byte = `NACK_BYTE;
          n.last_ack = 1'b0;
          n.msg_st = MSG_IDLE;
        end
        default: begin
          n.cur_byte = r.idle_byte;
        end
      endcase
    end

    // Receiver events are captured last so a new event is never lost to a consume.
    if (r.train_en && I_UPDATE_RX) begin
      n.upd_pend = 1'b1;
      n.upd_ok = I_UPDATE_OK;
      n.ta_corr = I_TA_CORR;
    end
    if (r.train_en && I_REPEAT_RX) begin
      n.rep_pend = 1'b1;
    end
  end

  // State register with asynchronous reset and a clock enable that freezes everything.
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      r <= '0;
      r.ntones <= `NTONES_RST;
      r.ce_len <= `CE_LEN_RST;
      r.tone_lo <= `TONE_LO_RST;
      r.tone_hi <= `TONE_HI_RST;
      r.msg_code <= `MSG_CODE_RST;
      r.idle_byte <= `IDLE_BYTE_RST;
      r.ta <= `TA_DEFAULT_SMP;
      r.ta_prev <= `TA_DEFAULT_SMP;
      r.iter <= `ITER_FIRST;
      r.scr <= `SCR_SEED;
    end else if (I_CE) begin
      r <= n;
    end
  end

  // Outputs straight from the state record; the slave never stalls and always answers OKAY.
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_HRDATA = r.rd_data;
  assign O_TONE_VALID = r.tone_valid;
  assign O_TONE = r.tone_pt;
  assign O_SYM_START = r.sym_start;
  assign O_TIMING_ADV = r.ta;
  assign O_ITERATION = r.iter;
  assign O_PSD_SEL = r.psd_sel;
  assign O_SYNC_DONE = r.sync_done;

endmodule

`default_nettype wire

// ### verif/dmt_seq_sva.sv
// Checker for the sequencer ports: bus answer, tone stream order and points, iteration steps.
// Assumes it is bound to the sequencer top module and sees only its ports.
`default_nettype none
`include "dmt_seq_regs.svh"
module dmt_seq_sva
  import dmt_seq_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_TONE_READY,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic O_TONE_VALID,
  input wire tone_pt_t O_TONE,
  input wire logic O_SYM_START,
  input wire logic [15:0] O_TIMING_ADV,
  input wire logic [7:0] O_ITERATION
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  // A tone handed over, and the first tone of a symbol.
  sequence s_take;
    O_TONE_VALID && I_TONE_READY;
  endsequence
  sequence s_first;
    O_TONE_VALID && O_TONE.idx == 13'h0000;
  endsequence
  // The slave never waits and always answers OKAY.
  property p_okay;
    O_HREADYOUT == 1'b1 && O_HRESP == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus slave stalled or answered with an error");
  // First cycle after reset carries the default advance and the first iteration.
  property p_reset_vals;
    $fell(I_SYS_RST) |-> O_TIMING_ADV == `TA_DEFAULT_SMP && O_ITERATION == `ITER_FIRST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("wrong advance or iteration after reset");
  // A symbol opens with no tone pending, then tone zero.
  property p_sym_first;
    O_SYM_START |-> !O_TONE_VALID ##1 s_first;
  endproperty
  a_sym_first: assert property (p_sym_first) else $error("symbol did not open with tone zero");
  // Tones follow in ascending index order.
  property p_tone_order;
    s_take |=> !O_TONE_VALID || O_TONE.idx == $past(O_TONE.idx) + 13'h0001;
  endproperty
  a_tone_order: assert property (p_tone_order) else $error("tone index skipped or repeated");
  // A stalled tone stays put.
  property p_tone_hold;
    O_TONE_VALID && !I_TONE_READY |=> O_TONE_VALID && $stable(O_TONE);
  endproperty
  a_tone_hold: assert property (p_tone_hold) else $error("tone changed while stalled");
  // Allowed tones carry a unit 4QAM point, others carry zero.
  property p_point;
    O_TONE_VALID |-> (O_TONE.en ? O_TONE.x[0] && O_TONE.y[0] : O_TONE.x == 2'sh0 && O_TONE.y == 2'sh0);
  endproperty
  a_point: assert property (p_point) else $error("tone point off the 4QAM grid");
  // The DC point is never rotated, so both coordinates agree.
  property p_dc;
    O_TONE_VALID && O_TONE.en && O_TONE.idx == 13'h0000 |-> O_TONE.x == O_TONE.y;
  endproperty
  a_dc: assert property (p_dc) else $error("DC tone was rotated");
  // The iteration moves by one step or restarts at the first.
  property p_iter_step;
    $changed(O_ITERATION) |-> O_ITERATION == $past(O_ITERATION) + 8'h01 ||
      O_ITERATION == $past(O_ITERATION) - 8'h01 || O_ITERATION == `ITER_FIRST;
  endproperty
  a_iter_step: assert property (p_iter_step) else $error("iteration jumped");
endmodule
bind dmt_training_symbol_sequencer dmt_seq_sva chk_u (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST),
  .I_TONE_READY(I_TONE_READY), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_TONE_VALID(O_TONE_VALID),
  .O_TONE(O_TONE), .O_SYM_START(O_SYM_START), .O_TIMING_ADV(O_TIMING_ADV), .O_ITERATION(O_ITERATION));
`default_nettype wire

// ### verif/dmt_tone_sink.sv
// Line-side consumer model: free-running sample strobe and a tone ready pattern.
// Assumes the sequencer clock; slow makes it accept one tone in eight cycles.
`default_nettype none
module dmt_tone_sink (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  output logic o_ready,
  output logic o_stb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] phase_reg;
  // Strobe every second cycle; ready follows the phase so stalls land on varied tones.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= 3'h0;
      o_ready <= 1'b0;
      o_stb <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
      o_stb <= phase_reg[0];
      o_ready <= i_slow ? (phase_reg == 3'h7) : (phase_reg[1:0] != 2'h2);
    end
  end
endmodule
`default_nettype wire

// ### verif/dmt_training_symbol_sequencer_tb.sv
// Bench for the sequencer: registers, message bytes per symbol, tone points, iterations, sync burst.
// Assumes the tone sink model and the bound checker are compiled first.
`default_nettype none
`include "dmt_seq_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module dmt_training_symbol_sequencer_tb import dmt_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, hsel, hwrite, upd, upd_ok, rep, slow, ready, stb, hready, hresp, tvalid, sstart, psel, sdone, ce;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [15:0] corr, ta;
  logic [7:0] iter;
  logic [1:0] pr [0:19];
  tone_pt_t tone;
  int fails = 0, n_checks = 0, seed = 95508, cnt = 0, last_len = 0;
  dmt_training_symbol_sequencer dut_u (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp), .I_SAMPLE_STB(stb),
    .I_TONE_READY(ready), .O_TONE_VALID(tvalid), .O_TONE(tone), .O_SYM_START(sstart), .I_UPDATE_RX(upd),
    .I_UPDATE_OK(upd_ok), .I_TA_CORR(corr), .I_REPEAT_RX(rep), .O_TIMING_ADV(ta), .O_ITERATION(iter),
    .O_PSD_SEL(psel), .O_SYNC_DONE(sdone));
  dmt_tone_sink sink_u (.i_clk(clk), .i_rst(rst), .i_slow(slow), .o_ready(ready), .o_stb(stb));
  // Clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Counts sample strobes from one symbol start to the next.
  always @(posedge clk) begin
    if (sstart === 1'b1) begin
      last_len <= cnt;
      cnt <= int'(stb);
    end else begin
      cnt <= cnt + int'(stb);
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic give_up();
    `CHK(1'b0, 1'b1)
    tally_and_finish();
  endtask
  // One single AHB-Lite transfer; waits for hready in both phases.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 40);
    rd = hrdata;
    if (k >= 40) give_up();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    `CHK(d, e)
  endtask
  // Rotation pairs of one symbol: scrambler seeded with ones, two bits per tone.
  task automatic scr_init();
    logic [10:0] s;
    logic [39:0] d;
    s = 11'h7ff;
    for (int i = 0; i < 40; i++) begin
      d[i] = s[8] ^ s[10];
      s = {s[9:0], d[i]};
    end
    for (int j = 0; j < 20; j++) pr[j] = {d[2 * j], d[2 * j + 1]};
  endtask
  // Training value of tone j for message byte b.
  function automatic logic [1:0] tval(int j, logic [7:0] b);
    int m;
    m = j % 10;
    if (m % 2 == 1 && m < 9) return {b[m], b[m - 1]};
    return 2'h0;
  endfunction
  // Expected point: unrotated first-quadrant base, then rotation, DC left alone.
  function automatic tone_pt_t exp_pt(int j, logic [1:0] v);
    tone_pt_t p;
    logic signed [1:0] x, y;
    x = v[1] ? 2'sh3 : 2'sh1;
    y = v[0] ? 2'sh3 : 2'sh1;
    p.idx = 13'(j);
    p.en = (j <= 16);
    case (j == 0 ? 2'h0 : pr[j])
      2'h1: {p.x, p.y} = {-y, x};
      2'h3: {p.x, p.y} = {-x, -y};
      2'h2: {p.x, p.y} = {y, -x};
      default: {p.x, p.y} = {x, y};
    endcase
    if (!p.en) {p.x, p.y} = 4'h0;
    return p;
  endfunction
  // Checks one symbol; ev 1 update, 2 repeat, 3 rejected update, 4 start the sync burst.
  task automatic run_sym(input logic [7:0] b, input bit sync, input int ev, input bit ck);
    int k, t;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (sstart !== 1'b1 && k < 400);
    if (k >= 400) give_up();
    fork
      begin
        if (ev == 1 || ev == 3) upd <= 1'b1;
        if (ev == 2) rep <= 1'b1;
        upd_ok <= (ev == 1);
        if (ev == 4) wr(`REG_CTRL, 32'h1d);
        @(posedge clk);
        upd <= 1'b0;
        rep <= 1'b0;
      end
      for (int j = 0; j < 20; j++) begin
        t = 0;
        do begin
          @(posedge clk);
          t++;
        end while (!(tvalid === 1'b1 && ready === 1'b1) && t < 400);
        if (t >= 400) give_up();
        `CHK(tone, exp_pt(j, sync ? b[1:0] : tval(j, b)))
      end
    join
    if (ck) `CHK(last_len == 24 || last_len == 25, 1'b1)
  endtask
  // Main sequence.
  initial begin
    int k, n;
    logic [7:0] mc, md, ib;
    logic [7:0] eb [0:20];
    bit adv;
    rst = 1'b1;
    {hsel, hwrite, upd, upd_ok, rep, slow} = 6'h0;
    ce = 1'b1;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    mc = 8'($random(seed));
    md = 8'($random(seed));
    ib = 8'($random(seed));
    corr = 16'($random(seed) % 16);
    eb = '{mc, md, 8'hff, mc, md, 8'h00, ib, ib, ib, ib, ib, 8'h00, ib, ib, ib, ib, ib, 8'hff, ib, 8'hff, ib};
    scr_init();
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(ta, `TA_DEFAULT_SMP)
    `CHK(iter, `ITER_FIRST)
    `CHK(sdone, 1'b0)
    rd_chk(`REG_NTONES, 32'(`NTONES_RST));
    rd_chk(`REG_CE_LEN, 32'(`CE_LEN_RST));
    rd_chk(`REG_TONE_HI, 32'(`TONE_HI_RST));
    wr(`REG_NTONES, 32'h14);
    wr(`REG_CE_LEN, 32'h4);
    wr(`REG_TONE_LO, 32'h0);
    wr(`REG_TONE_HI, 32'h10);
    wr(`REG_MSG_CODE, {24'h0, mc});
    wr(`REG_MSG_LEN, 32'h1);
    wr(`REG_MSG_DATA, {24'h0, md});
    wr(`REG_IDLE_BYTE, {24'h0, ib});
    rd_chk(`REG_MSG_CODE, {24'h0, mc});
    rd_chk(`REG_MSG_DATA, 32'h0);
    rd_chk(8'h3c, 32'h0);
    $display("test registers done");
    wr(`REG_CTRL, 32'h0d);
    for (int i = 0; i < 21; i++) begin
      adv = (i == 10 || i >= 16);
      // Central side answers each acknowledge and the first reject with a new update or a repeat, the last reject with the sync burst.
      run_sym(eb[i], 1'b0, i == 4 ? 1 : (i == 10 || i == 18) ? 2 : i == 16 ? 3 : i == 20 ? 4 : 0, i > 0);
      `CHK(iter, adv ? 8'h02 : 8'h01)
      `CHK(ta, adv ? `TA_DEFAULT_SMP + corr : `TA_DEFAULT_SMP)
    end
    `CHK(psel, 1'b1)
    $display("test messages done");
    slow <= 1'b1;
    for (int s = 0; s < 15; s++) run_sym((s < 5 || s > 9) ? 8'h03 : 8'h00, 1'b1, 0, 1'b0);
    k = 0;
    while (sdone !== 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    `CHK(sdone, 1'b1)
    n = 0;
    repeat (100) begin
      @(posedge clk);
      if (sstart === 1'b1) n++;
    end
    `CHK(n, 0)
    rd_chk(`REG_CTRL, 32'h0c);
    // With the clock enable low a register write must leave no trace.
    ce <= 1'b0;
    wr(`REG_TA, 32'h1234);
    ce <= 1'b1;
    rd_chk(`REG_TA, 32'(16'(`TA_DEFAULT_SMP + corr)));
    $display("test sync burst done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
